// >>> shared/iee_pkg.sv
// Shared constants, types and state encodings for the EEPROM slave engine.
// Assumes a 250 MHz core clock and a word-wide external cell array port.
package iee_pkg;

  // Core clock and the internal write cycle duration.
  localparam int CORE_CLK_PERIOD_NS = 4;
  localparam int INTERNAL_WRITE_CYCLE_TIME_NS = 100000;
  localparam int INTERNAL_WRITE_CYCLES =
    INTERNAL_WRITE_CYCLE_TIME_NS / CORE_CLK_PERIOD_NS;

  // Address, data and ECC word geometry.
  localparam int ADDR_W = 17;
  localparam int DATA_W = 8;
  localparam int WORD_BYTES = 4;
  localparam int WORD_W = 32;
  localparam int CHECK_W = 6;
  localparam int CODE_W = 38;
  localparam int WORD_ADDR_W = 15;
  localparam int PAGE_BYTES = 256;
  localparam logic [5:0] LAST_ROW_WORD = 6'h3F;

  // Select byte layout.
  localparam int SEL_RW_POS = 0;
  localparam int SEL_TOP_ADDR_POS = 1;
  localparam int SEL_CE_LOW_POS = 2;
  localparam int SEL_CE_HIGH_POS = 3;
  localparam int SEL_TYPE_LSB = 4;
  // Device type code; the value is arbitrary.
  localparam logic [3:0] DEV_TYPE_ID = 4'h6;

  // Bit slot counts within a byte frame.
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] STOP_SLOT_BITS = 4'h1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SELECT,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_WRITE_DATA,
    ST_READ_DATA,
    ST_IGNORE,
    ST_COMMIT
  } iee_state_type;

endpackage : iee_pkg

// >>> core/iee_link_capture.sv
// Link front end: samples the data line on the serial clock and carries
// bits, clock level and data level into the core clock domain.
// Assumes the serial clock is a clock port that may stop between frames.
`timescale 1ns/10ps
`default_nettype none
module iee_link_capture
  import iee_pkg::*;
(
  // Core clock, reset and enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // Serial link
  input wire logic sclClk,
  input wire logic sdaIn,
  // Core side events and levels
  output logic bitStrobe,
  output logic bitData,
  output logic sclLvl,
  output logic sdaLvl
);

  typedef struct packed {
    logic capTog;
    logic capBit;
  } iee_cap_type;

  typedef struct packed {
    logic [3:0] tog;
    logic [1:0] bitSy;
    logic [1:0] scl;
    logic [1:0] sda;
  } iee_sync_type;

  iee_cap_type cap_r;
  iee_cap_type cap_nxt;
  iee_sync_type sy_r;
  iee_sync_type sy_nxt;

  // The master holds data stable across the rising edge, so one capture
  // on the link clock is safe; the toggle then marks the new bit.
  always_comb begin
    cap_nxt = cap_r;
    cap_nxt.capTog = ~cap_r.capTog;
    cap_nxt.capBit = sdaIn;
  end

  always_ff @(posedge sclClk or negedge rstn) begin
    if (!rstn) begin
      cap_r <= '0;
    end else begin
      cap_r <= cap_nxt;
    end
  end

  // The bit value is held for a whole clock period, so it is settled a
  // cycle before the delayed toggle edge reads it. Its path is one stage
  // shorter than the toggle's, so the two can never resolve apart.
  always_comb begin
    sy_nxt = sy_r;
    sy_nxt.tog = {sy_r.tog[2:0], cap_r.capTog};
    sy_nxt.bitSy = {sy_r.bitSy[0], cap_r.capBit};
    sy_nxt.scl = {sy_r.scl[0], sclClk};
    sy_nxt.sda = {sy_r.sda[0], sdaIn};
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sy_r <= '0;
    end else if (ce) begin
      sy_r <= sy_nxt;
    end
  end

  assign bitStrobe = sy_r.tog[3] ^ sy_r.tog[2];
  assign bitData = sy_r.bitSy[1];
  assign sclLvl = sy_r.scl[1];
  assign sdaLvl = sy_r.sda[1];

endmodule : iee_link_capture
`default_nettype wire

// >>> core/iee_eeprom_slave.sv
// Slave protocol engine of a two-wire serial EEPROM with 17-bit addressing,
// page buffer, word ECC and a timed internal write cycle.
// Assumes an external cell array with combinational read of the word
// addressed while the read enable is high, and a write on the clock edge.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Transmitter releases data; receiver acks ninth pulse.
// - Capture data on each serial clock rise.
// - Respond only when chip address matches pins.
// - Eighth select bit: one reads, zero writes.
// - Ack matching select; otherwise release until start.
// - Write select: ack two address bytes, await data.
// - Address: b16 from select, then high, low.
// - Write cycle only on stop in tenth slot.
// - After write, counter points past last byte.
// - Busy: release line, ignore all, master polls.
// - Protect high: nack data, leave memory unchanged.
// - Page holds up to 256 bytes, same row.
// - Page write increments only low eight bits.
// - Words carry six check bits; correct single errors.
// - Every write rewrites whole word with checks.
// - Reads ignore the write protect level.
// - Each completed byte read advances the counter.
// - Random read: dummy write, restart, read, nack.
// - Current read returns byte at counter.
// - Sequential read continues on ack, wraps to zero.
// - Start and stop are data edges, clock high.
// - Chip address bits b3, b2 versus pins.
// - Master nack after read byte: return to standby.
// - Protect high still acks select and address.
module iee_eeprom_slave
  import iee_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = INTERNAL_WRITE_CYCLES
)
(
  // Core clock, reset and enable
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic ce,
  // Serial link
  input wire logic sclClk,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe_n,
  // Straps and protection
  input wire logic chipEnablePinLowBit,
  input wire logic chipEnablePinHighBit,
  input wire logic writeProtectInput,
  // Cell array port
  output logic memRdEn,
  output logic memWrEn,
  output logic [WORD_ADDR_W-1:0] memWordAddr,
  output logic [CODE_W-1:0] memWrData,
  input wire logic [CODE_W-1:0] memRdData,
  // Status
  output logic busy
);

  localparam int TIMER_W = $clog2(WRITE_CYCLES + 1);

  typedef struct packed {
    iee_state_type st;
    iee_state_type nxtSt;
    logic [3:0] bitCnt;
    logic ackPh;
    logic ackGo;
    logic [DATA_W-1:0] rxShift;
    logic [DATA_W-1:0] txByte;
    logic [ADDR_W-1:0] addrCnt;
    logic [PAGE_BYTES-1:0][DATA_W-1:0] pageBuf;
    logic [PAGE_BYTES-1:0] dirty;
    logic fetchPend;
    logic [5:0] wordIdx;
    logic cPhase;
    logic cDone;
    logic [TIMER_W-1:0] timer;
    logic [1:0] ceLowSy;
    logic [1:0] ceHighSy;
    logic [1:0] wpSy;
    logic prevScl;
    logic prevSda;
    logic sdaOutVal;
    logic sdaOeN;
    logic memRdEn;
    logic memWrEn;
    logic [WORD_ADDR_W-1:0] memWordAddr;
    logic [CODE_W-1:0] memWrData;
    logic busy;
  } iee_slave_type;

  iee_slave_type s_r;
  iee_slave_type s_nxt;

  logic bitStrobe;
  logic bitData;
  logic sclLvl;
  logic sdaLvl;

  // Single-error-correcting code over a 32-bit word, six check bits.
  function automatic logic [CODE_W-1:0] eccEncode(
    input logic [WORD_W-1:0] d
  );
    logic [CODE_W:0] c;
    int k;
    c = '0;
    k = 0;
    for (int p = 1; p <= CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        c[p] = d[k];
        k++;
      end
    end
    for (int i = 0; i < CHECK_W; i++) begin
      for (int p = 1; p <= CODE_W; p++) begin
        if ((((p >> i) & 1) != 0) && ((p & (p - 1)) != 0)) begin
          c[1 << i] = c[1 << i] ^ c[p];
        end
      end
    end
    return c[CODE_W:1];
  endfunction : eccEncode

  function automatic logic [WORD_W-1:0] eccDecode(
    input logic [CODE_W-1:0] code
  );
    logic [CODE_W:0] c;
    logic [WORD_W-1:0] d;
    logic [CHECK_W-1:0] syn;
    int k;
    c = {code, 1'b0};
    d = '0;
    syn = '0;
    k = 0;
    for (int p = 1; p <= CODE_W; p++) begin
      if (c[p]) begin
        syn = syn ^ CHECK_W'(p);
      end
    end
    if ((syn != '0) && (int'(syn) <= CODE_W)) begin
      c[syn] = ~c[syn];
    end
    for (int p = 1; p <= CODE_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[k] = c[p];
        k++;
      end
    end
    return d;
  endfunction : eccDecode

  iee_link_capture i_iee_link_capture (
    .core_clk(core_clk),
    .rstn(rstn),
    .ce(ce),
    .sclClk(sclClk),
    .sdaIn(sdaIn),
    .bitStrobe(bitStrobe),
    .bitData(bitData),
    .sclLvl(sclLvl),
    .sdaLvl(sdaLvl)
  );

  always_comb begin
    logic startEv;
    logic stopEv;
    logic sclFall;
    logic [DATA_W-1:0] rx;
    logic [WORD_W-1:0] word;
    logic [ADDR_W-1:0] nextAddr;
    logic [7:0] base;
    startEv = 1'b0;
    stopEv = 1'b0;
    sclFall = 1'b0;
    rx = '0;
    word = '0;
    nextAddr = '0;
    base = '0;
    s_nxt = s_r;
    s_nxt.memRdEn = 1'b0;
    s_nxt.memWrEn = 1'b0;
    s_nxt.ceLowSy = {s_r.ceLowSy[0], chipEnablePinLowBit};
    s_nxt.ceHighSy = {s_r.ceHighSy[0], chipEnablePinHighBit};
    s_nxt.wpSy = {s_r.wpSy[0], writeProtectInput};
    s_nxt.prevScl = sclLvl;
    s_nxt.prevSda = sdaLvl;
    startEv = s_r.prevScl & sclLvl & s_r.prevSda & ~sdaLvl;
    stopEv = s_r.prevScl & sclLvl & ~s_r.prevSda & sdaLvl;
    sclFall = s_r.prevScl & ~sclLvl;

    // The array answers in the cycle its read enable is high.
    if (s_r.fetchPend) begin
      s_nxt.fetchPend = 1'b0;
      word = eccDecode(memRdData);
      s_nxt.txByte = word[{s_r.addrCnt[1:0], 3'b000} +: DATA_W];
    end

    if (s_r.st == ST_COMMIT) begin
      // The bus is not watched at all here; polling masters see no ack.
      s_nxt.sdaOeN = 1'b1;
      s_nxt.timer = s_r.timer + TIMER_W'(1);
      if (!s_r.cDone) begin
        base = {s_r.wordIdx, 2'b00};
        if (!s_r.cPhase) begin
          if (s_r.dirty[base +: WORD_BYTES] != '0) begin
            s_nxt.memRdEn = 1'b1;
            s_nxt.memWordAddr = {s_r.addrCnt[ADDR_W-1:8], s_r.wordIdx};
            s_nxt.cPhase = 1'b1;
          end else if (s_r.wordIdx == LAST_ROW_WORD) begin
            s_nxt.cDone = 1'b1;
          end else begin
            s_nxt.wordIdx = s_r.wordIdx + 6'h1;
          end
        end else begin
          // Merge into the corrected old word and rewrite all of it.
          word = eccDecode(memRdData);
          for (int b = 0; b < WORD_BYTES; b++) begin
            if (s_r.dirty[base + 8'(b)]) begin
              word[b*DATA_W +: DATA_W] = s_r.pageBuf[base + 8'(b)];
            end
          end
          s_nxt.memWrData = eccEncode(word);
          s_nxt.memWrEn = 1'b1;
          s_nxt.cPhase = 1'b0;
          if (s_r.wordIdx == LAST_ROW_WORD) begin
            s_nxt.cDone = 1'b1;
          end else begin
            s_nxt.wordIdx = s_r.wordIdx + 6'h1;
          end
        end
      end else if (32'(s_r.timer) >= WRITE_CYCLES - 1) begin
        // The counter already points past the last byte taken.
        s_nxt.st = ST_IDLE;
        s_nxt.busy = 1'b0;
        s_nxt.dirty = '0;
      end
    end else if (startEv) begin
      // A restart abandons any unfinished page without writing it.
      s_nxt.st = ST_SELECT;
      s_nxt.bitCnt = '0;
      s_nxt.ackPh = 1'b0;
      s_nxt.sdaOeN = 1'b1;
      s_nxt.dirty = '0;
    end else if (stopEv) begin
      s_nxt.sdaOeN = 1'b1;
      if ((s_r.st == ST_WRITE_DATA) && (s_r.bitCnt == STOP_SLOT_BITS) &&
          !s_r.ackPh && (s_r.dirty != '0)) begin
        s_nxt.st = ST_COMMIT;
        s_nxt.busy = 1'b1;
        s_nxt.wordIdx = '0;
        s_nxt.cPhase = 1'b0;
        s_nxt.cDone = 1'b0;
        s_nxt.timer = '0;
      end else begin
        s_nxt.st = ST_IDLE;
        s_nxt.dirty = '0;
      end
    end else if (bitStrobe) begin
      unique case (s_r.st)
        ST_SELECT, ST_ADDR_HI, ST_ADDR_LO, ST_WRITE_DATA: begin
          if (s_r.bitCnt < ACK_SLOT) begin
            rx = {s_r.rxShift[DATA_W-2:0], bitData};
            s_nxt.rxShift = rx;
            s_nxt.bitCnt = s_r.bitCnt + 4'h1;
            if (s_r.bitCnt == LAST_DATA_BIT) begin
              s_nxt.ackGo = 1'b1;
              unique case (s_r.st)
                ST_SELECT: begin
                  if ((rx[7:SEL_TYPE_LSB] != DEV_TYPE_ID) ||
                      (rx[SEL_CE_HIGH_POS] != s_r.ceHighSy[1]) ||
                      (rx[SEL_CE_LOW_POS] != s_r.ceLowSy[1])) begin
                    s_nxt.st = ST_IGNORE;
                    s_nxt.ackGo = 1'b0;
                  end else if (rx[SEL_RW_POS]) begin
                    s_nxt.nxtSt = ST_READ_DATA;
                    s_nxt.memRdEn = 1'b1;
                    s_nxt.memWordAddr = s_r.addrCnt[ADDR_W-1:2];
                    s_nxt.fetchPend = 1'b1;
                  end else begin
                    s_nxt.nxtSt = ST_ADDR_HI;
                    s_nxt.addrCnt[ADDR_W-1] = rx[SEL_TOP_ADDR_POS];
                    s_nxt.dirty = '0;
                  end
                end
                ST_ADDR_HI: begin
                  s_nxt.addrCnt[15:8] = rx;
                  s_nxt.nxtSt = ST_ADDR_LO;
                end
                ST_ADDR_LO: begin
                  s_nxt.addrCnt[7:0] = rx;
                  s_nxt.nxtSt = ST_WRITE_DATA;
                end
                default: begin
                  s_nxt.nxtSt = ST_WRITE_DATA;
                  if (s_r.wpSy[1]) begin
                    s_nxt.ackGo = 1'b0;
                  end else begin
                    s_nxt.pageBuf[s_r.addrCnt[7:0]] = rx;
                    s_nxt.dirty[s_r.addrCnt[7:0]] = 1'b1;
                    s_nxt.addrCnt[7:0] = s_r.addrCnt[7:0] + 8'h01;
                  end
                end
              endcase
            end
          end
        end
        ST_READ_DATA: begin
          if (s_r.bitCnt < ACK_SLOT) begin
            s_nxt.bitCnt = s_r.bitCnt + 4'h1;
          end else begin
            // Master acknowledge slot of a byte sent by this device.
            nextAddr = s_r.addrCnt + 17'h0_0001;
            s_nxt.addrCnt = nextAddr;
            if (!bitData) begin
              s_nxt.bitCnt = '0;
              s_nxt.memRdEn = 1'b1;
              s_nxt.memWordAddr = nextAddr[ADDR_W-1:2];
              s_nxt.fetchPend = 1'b1;
            end else begin
              s_nxt.st = ST_IDLE;
            end
          end
        end
        ST_IDLE, ST_IGNORE, ST_COMMIT: begin
          s_nxt.bitCnt = s_r.bitCnt;
        end
      endcase
    end else if (sclFall) begin
      unique case (s_r.st)
        ST_SELECT, ST_ADDR_HI, ST_ADDR_LO, ST_WRITE_DATA: begin
          if ((s_r.bitCnt == ACK_SLOT) && !s_r.ackPh) begin
            s_nxt.ackPh = 1'b1;
            s_nxt.sdaOeN = ~s_r.ackGo;
          end else if (s_r.ackPh) begin
            s_nxt.ackPh = 1'b0;
            s_nxt.bitCnt = '0;
            s_nxt.st = s_r.nxtSt;
            // Reads are independent of protection and start at once.
            s_nxt.sdaOeN = (s_r.nxtSt == ST_READ_DATA) ?
                           s_r.txByte[7] : 1'b1;
          end
        end
        ST_READ_DATA: begin
          s_nxt.sdaOeN = (s_r.bitCnt < ACK_SLOT) ?
                         s_r.txByte[~s_r.bitCnt[2:0]] : 1'b1;
        end
        ST_IDLE, ST_IGNORE, ST_COMMIT: begin
          s_nxt.sdaOeN = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.sdaOeN <= 1'b1;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign sdaOut = s_r.sdaOutVal;
  assign sdaOe_n = s_r.sdaOeN;
  assign memRdEn = s_r.memRdEn;
  assign memWrEn = s_r.memWrEn;
  assign memWordAddr = s_r.memWordAddr;
  assign memWrData = s_r.memWrData;
  assign busy = s_r.busy;

endmodule : iee_eeprom_slave
`default_nettype wire

// >>> sim/iee_eeprom_slave_chk.sv
// Port checker for the EEPROM slave engine, bound to its top module.
// Assumes the serial clock stays high or low for at least 25 core cycles.
`timescale 1ns/10ps
`default_nettype none
module iee_eeprom_slave_chk #(
  parameter int unsigned WRITE_CYCLES = 1000
)(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Link
  input wire logic sclClk,
  input wire logic sdaOut,
  input wire logic sdaOe_n,
  // Cell array and status
  input wire logic memRdEn,
  input wire logic memWrEn,
  input wire logic busy
);
  int busyCnt_r;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busyCnt_r <= 0;
    end else begin
      busyCnt_r <= busy ? busyCnt_r + 1 : 0;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_busy_length: assert property ($fell(busy) |->
    busyCnt_r + 2 >= WRITE_CYCLES && busyCnt_r <= WRITE_CYCLES)
    else $error("write cycle length wrong");
  a_busy_released: assert property (busy |-> sdaOe_n)
    else $error("data line driven while busy");
  a_write_in_busy: assert property (memWrEn |-> busy)
    else $error("cell write outside write cycle");
  a_word_rewrite: assert property (memWrEn |-> $past(memRdEn))
    else $error("word written without being read");
  a_busy_commits: assert property ($rose(busy) |-> ##[0:140] memWrEn)
    else $error("write cycle stored nothing");
  a_open_drain: assert property (!sdaOe_n |-> !sdaOut)
    else $error("data line driven high");
  a_drive_scl_low: assert property ($fell(sdaOe_n) |-> !sclClk)
    else $error("data line pulled while clock high");
  a_scl_high_hold: assert property ($rose(sclClk) |=> $stable(sdaOe_n)[*8])
    else $error("data line moved while clock high");
  a_read_released: assert property (memRdEn && !busy |-> sdaOe_n)
    else $error("fetch while device drives line");
  cover property ($rose(busy));
  cover property ($fell(sdaOe_n));
  cover property (memRdEn && !busy);
endmodule : iee_eeprom_slave_chk
bind iee_eeprom_slave iee_eeprom_slave_chk #(.WRITE_CYCLES(WRITE_CYCLES))
  i_iee_eeprom_slave_chk (.core_clk(core_clk), .rstn(rstn), .sclClk(sclClk),
  .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .memRdEn(memRdEn), .memWrEn(memWrEn),
  .busy(busy));
`default_nettype wire

// >>> sim/iee_bus_master.sv
// Two-wire bus master model with start, stop and byte tasks.
// Assumes a pull-up on the data line; the clock idles high between frames.
`timescale 1ns/10ps
`default_nettype none
module iee_bus_master (
  // Bus
  output logic sclClk,
  output logic sdaDrv,
  input wire logic sdaBus
);
  logic tick;
  // A 30 ns tick; each clock phase spans four ticks to give the core time.
  // The odd offset keeps every link edge off the core clock edges.
  initial begin
    tick = 0;
    sclClk = 1;
    sdaDrv = 1;
    #8;
    forever #15 tick = ~tick;
  end
  task automatic w(input int n);
    repeat (n) @(posedge tick);
  endtask : w
  task automatic start();
    sdaDrv = 1;
    w(2);
    sclClk = 1;
    w(4);
    sdaDrv = 0;
    w(4);
    sclClk = 0;
    w(2);
  endtask : start
  task automatic stop();
    sdaDrv = 0;
    w(2);
    sclClk = 1;
    w(4);
    sdaDrv = 1;
    w(4);
  endtask : stop
  task automatic bitx(input logic b, output logic s);
    sdaDrv = b;
    w(2);
    sclClk = 1;
    w(2);
    s = sdaBus;
    w(2);
    sclClk = 0;
    w(2);
  endtask : bitx
  task automatic wrByte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(b[i], s);
    bitx(1'b1, s);
    ack = ~s;
  endtask : wrByte
  task automatic rdByte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(nack, s);
  endtask : rdByte
endmodule : iee_bus_master
`default_nettype wire

// >>> sim/test_iee_eeprom_slave.sv
// Testbench for the EEPROM slave engine with a bus master and cell array.
// Assumes the cell array reads combinationally and starts all zero.
`timescale 1ns/10ps
`default_nettype none
module test_iee_eeprom_slave;
  import iee_pkg::*;
  logic core_clk, rstn, wp, sclClk, sdaDrv, sdaBus, sdaOut, sdaOe_n, k;
  logic memRdEn, memWrEn, busy;
  logic [1:0] pins;
  logic [WORD_ADDR_W-1:0] memWordAddr;
  logic [CODE_W-1:0] memWrData, memRdData;
  logic [CODE_W-1:0] mem [0:32767];
  int fails, n_checks;
  assign sdaBus = sdaDrv & (sdaOe_n | sdaOut);
  assign memRdData = mem[memWordAddr];
  always @(posedge core_clk) if (memWrEn) mem[memWordAddr] <= memWrData;
  initial begin
    core_clk = 0;
    forever #2 core_clk = ~core_clk;
  end
  iee_eeprom_slave #(.WRITE_CYCLES(1000)) i_iee_eeprom_slave (
    .core_clk(core_clk), .rstn(rstn), .ce(1'b1), .sclClk(sclClk),
    .sdaIn(sdaBus), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
    .chipEnablePinLowBit(pins[0]), .chipEnablePinHighBit(pins[1]),
    .writeProtectInput(wp), .memRdEn(memRdEn), .memWrEn(memWrEn),
    .memWordAddr(memWordAddr), .memWrData(memWrData),
    .memRdData(memRdData), .busy(busy));
  iee_bus_master i_iee_bus_master (.sclClk(sclClk), .sdaDrv(sdaDrv),
    .sdaBus(sdaBus));
  task automatic chkFlag(input string what, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", what, e, g);
    end
  endtask : chkFlag
  task automatic chkByte(input string what, input logic [7:0] e,
                         input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chkByte
  function automatic logic [7:0] sel(input logic [1:0] c, input logic a,
                                     input logic rd);
    return {DEV_TYPE_ID, c, a, rd};
  endfunction : sel
  task automatic addr(input logic [16:0] a);
    i_iee_bus_master.start();
    i_iee_bus_master.wrByte(sel(pins, a[16], 1'b0), k);
    chkFlag("select ack", 1'b1, k);
    i_iee_bus_master.wrByte(a[15:8], k);
    chkFlag("address high ack", 1'b1, k);
    i_iee_bus_master.wrByte(a[7:0], k);
    chkFlag("address low ack", 1'b1, k);
  endtask : addr
  task automatic poll(input logic expBusy);
    int n;
    n = 0;
    k = 0;
    while (!k && n < 20) begin
      i_iee_bus_master.start();
      i_iee_bus_master.wrByte(sel(pins, 1'b0, 1'b0), k);
      i_iee_bus_master.stop();
      n++;
    end
    chkFlag("ready after polling", 1'b1, k);
    chkFlag("select refused while busy", expBusy, n > 1);
  endtask : poll
  task automatic write(input logic [16:0] a, input logic [7:0] d[$]);
    addr(a);
    foreach (d[i]) begin
      i_iee_bus_master.wrByte(d[i], k);
      chkFlag("data ack", ~wp, k);
    end
    i_iee_bus_master.stop();
    @(negedge core_clk);
    chkFlag("write cycle started", ~wp, busy);
    poll(~wp);
  endtask : write
  task automatic read(input logic [16:0] a, input logic rnd,
                      input logic [7:0] e[$]);
    logic [7:0] v;
    if (rnd) addr(a);
    i_iee_bus_master.start();
    i_iee_bus_master.wrByte(sel(pins, a[16], 1'b1), k);
    chkFlag("read select ack", 1'b1, k);
    foreach (e[i]) begin
      i_iee_bus_master.rdByte(i == e.size() - 1, v);
      chkByte("read data", e[i], v);
    end
    chkFlag("line released after nack", 1'b1, sdaOe_n);
    i_iee_bus_master.stop();
  endtask : read
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #350000;
    fails++;
    end_of_test();
  end
  initial begin
    rstn = 0;
    wp = 0;
    pins = 2'b10;
    fails = 0;
    n_checks = 0;
    foreach (mem[i]) mem[i] = '0;
    repeat (8) @(negedge core_clk);
    rstn = 1;
    repeat (8) @(negedge core_clk);
    chkFlag("idle release", 1'b1, sdaOe_n);
    chkFlag("idle busy", 1'b0, busy);
    for (int c = 0; c < 4; c++) begin
      i_iee_bus_master.start();
      i_iee_bus_master.wrByte(sel(c[1:0], 1'b0, 1'b0), k);
      i_iee_bus_master.stop();
      chkFlag("chip address match", c == 2, k);
    end
    i_iee_bus_master.start();
    i_iee_bus_master.wrByte({~DEV_TYPE_ID, pins, 2'b00}, k);
    i_iee_bus_master.stop();
    chkFlag("wrong type ignored", 1'b0, k);
    $display("test select decode done");
    write(17'h0_0023, {8'hD4});
    write(17'h0_0020, {8'hA1, 8'hB2, 8'hC3});
    read(17'h0_0000, 1'b0, {8'hD4});
    read(17'h0_0020, 1'b1, {8'hA1, 8'hB2, 8'hC3, 8'hD4});
    $display("test write and counter done");
    write(17'h1_12FE, {8'h11, 8'h22, 8'h33, 8'h44});
    read(17'h1_12FE, 1'b1, {8'h11, 8'h22, 8'h00});
    read(17'h1_1200, 1'b1, {8'h33, 8'h44});
    write(17'h0_0000, {8'h77});
    write(17'h1_FFFF, {8'h88});
    read(17'h1_FFFF, 1'b1, {8'h88, 8'h77});
    $display("test row wrap and roll-over done");
    @(negedge core_clk);
    wp = 1;
    write(17'h0_0020, {8'h5A});
    read(17'h0_0020, 1'b1, {8'hA1});
    @(negedge core_clk);
    wp = 0;
    // A stop one bit into the next byte must drop the buffered byte.
    addr(17'h0_0040);
    i_iee_bus_master.wrByte(8'h99, k);
    chkFlag("early stop data ack", 1'b1, k);
    i_iee_bus_master.bitx(1'b0, k);
    i_iee_bus_master.stop();
    repeat (4) @(negedge core_clk);
    chkFlag("stop before data starts nothing", 1'b0, busy);
    read(17'h0_0040, 1'b1, {8'h00});
    $display("test protect and early stop done");
    // A single flipped bit in the stored word must be corrected on read.
    mem[8] = mem[8] ^ (38'h00_0000_0001 << 13);
    read(17'h0_0020, 1'b1, {8'hA1, 8'hB2, 8'hC3, 8'hD4});
    $display("test error correction done");
    end_of_test();
  end
endmodule : test_iee_eeprom_slave
`default_nettype wire
